/* File: design/qrw_pkg.sv */
package qrw_pkg;
    // read command codes on the serial link
    localparam logic [7:0] CMD_FAST_QUAD  = 8'hEB;
    localparam logic [7:0] CMD_WORD_QUAD  = 8'hE7;
    localparam logic [7:0] CMD_OCTAL_QUAD = 8'hE3;

    // link clocks spent in each phase
    localparam logic [3:0] CMD_CLKS       = 4'h8;
    localparam logic [3:0] ADDR_CLKS      = 4'h6;
    localparam logic [3:0] MODE_CLKS      = 4'h2;
    localparam logic [3:0] DUMMY_FAST     = 4'h4;
    localparam logic [3:0] DUMMY_WORD     = 4'h2;
    localparam logic [3:0] DUMMY_OCTAL    = 4'h0;

    // continuous read select pair value that skips the instruction
    localparam logic [1:0] CONT_SELECT    = 2'h2;

    // wrap setting: bit 2 disables, bits 1:0 pick the length
    localparam logic [2:0] WRAP_RESET     = 3'h4;
    localparam int         WRAP_DIS_BIT   = 2;
    localparam logic [7:0] WRAP_MIN_BYTES = 8'h08;

    localparam int         ADDR_W         = 24;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_CMD    = 3'b001,
        ST_ADDR   = 3'b010,
        ST_MODE   = 3'b011,
        ST_DUMMY  = 3'b100,
        ST_DATA   = 3'b101,
        ST_IGNORE = 3'b110
    } qrw_state_t;

    typedef enum logic [1:0] {
        KIND_FAST  = 2'b00,
        KIND_WORD  = 2'b01,
        KIND_OCTAL = 2'b10
    } qrw_kind_t;
endpackage : qrw_pkg

/* File: design/qrw_wrap_if.sv */
`timescale 1ns/100ps
interface qrw_wrap_if;
    import qrw_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic [2:0]        setting;
    logic              apply;
    logic [ADDR_W-1:0] next;
    logic [7:0]        mask;

    modport ctl  (output addr, output setting, output apply,
                  input  next, input  mask);
    modport unit (input  addr, input  setting, input  apply,
                  output next, output mask);
endinterface : qrw_wrap_if

/* File: design/qrw_wrap_unit.sv */
`timescale 1ns/100ps
module qrw_wrap_unit (
    qrw_wrap_if.unit w
);
    import qrw_pkg::*;

    logic [ADDR_W-1:0] inc;
    logic [7:0]        low;

    // next read address: plain increment, or stay inside the section
    always_comb begin
        w.mask = (WRAP_MIN_BYTES << w.setting[1:0]) - 8'h01;
        inc    = w.addr + 24'h000001;
        // bits above the mask are kept, so the section never leaves
        // its aligned slot inside the page
        low    = (w.addr[7:0] & ~w.mask) | (inc[7:0] & w.mask);
        if (w.apply) begin
            w.next = {w.addr[ADDR_W-1:8], low};
        end else begin
            w.next = inc;
        end
    end
endmodule : qrw_wrap_unit

/* File: design/qrw_read_seq.sv */
`timescale 1ns/100ps
module qrw_read_seq (
    input  wire logic                       i_clk,
    input  wire logic                       i_reset_n,
    input  wire logic                       i_cs_n,
    input  wire logic                       i_sclk,
    input  wire logic [3:0]                 i_quad_line,
    output logic      [3:0]                 o_quad_line,
    output logic      [3:0]                 o_quad_line_oe,
    input  wire logic                       i_quad_io_enable_bit,
    input  wire logic                       i_wrap_load,
    input  wire logic [2:0]                 i_wrap_setting,
    output logic      [qrw_pkg::ADDR_W-1:0] o_rd_addr,
    input  wire logic [7:0]                 i_rd_data,
    output logic                            o_cont_mode,
    output logic                            o_read_active
);
    import qrw_pkg::*;

    logic [5:0]        sync1_q;
    logic [5:0]        sync2_q;
    logic              sclk_prev_q;
    logic [3:0]        io;
    logic              sclk;
    logic              cs_hi;
    logic              rise;
    logic              fall;

    qrw_state_t        state_q, state_d;
    qrw_kind_t         kind_q, kind_d;
    logic [3:0]        cnt_q, cnt_d;
    logic [7:0]        cmd_q, cmd_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [7:0]        mode_q, mode_d;
    logic              cont_q, cont_d;
    logic [2:0]        wrap_q, wrap_d;
    logic [3:0]        out_q, out_d;
    logic [3:0]        lo_q, lo_d;
    logic              nib_q, nib_d;
    logic              oe_q, oe_d;
    logic              adv;

    qrw_wrap_if        wrap_bus ();

    // dummy clocks owed by each read kind
    function automatic logic [3:0] dummy_of(input qrw_kind_t k);
        case (k)
            KIND_FAST:  dummy_of = DUMMY_FAST;
            KIND_WORD:  dummy_of = DUMMY_WORD;
            KIND_OCTAL: dummy_of = DUMMY_OCTAL;
            default:    dummy_of = DUMMY_FAST;
        endcase
    endfunction : dummy_of

    // the link pins are asynchronous to i_clk: two stages each,
    // clock and data share the same latency so sampling stays aligned
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            // idle pin levels: cs high, clock low, so no false edge
            sync1_q     <= 6'h20;
            sync2_q     <= 6'h20;
            sclk_prev_q <= 1'b0;
        end else begin
            sync1_q     <= {i_cs_n, i_sclk, i_quad_line};
            sync2_q     <= sync1_q;
            sclk_prev_q <= sync2_q[4];
        end
    end

    // edges of the sampled link clock
    assign io    = sync2_q[3:0];
    assign sclk  = sync2_q[4];
    assign cs_hi = sync2_q[5];
    assign rise  = sclk & ~sclk_prev_q;
    assign fall  = ~sclk & sclk_prev_q;

    // address advance: taken when the low nibble goes out
    assign adv = (state_q == ST_DATA) && fall && nib_q && !cs_hi;

    // wrap applies to fast and word quad reads, never to octal word
    assign wrap_bus.addr    = addr_q;
    assign wrap_bus.setting = wrap_q;
    assign wrap_bus.apply   = !wrap_q[WRAP_DIS_BIT] &&
                              (kind_q != KIND_OCTAL);

    qrw_wrap_unit u_wrap (
        .w (wrap_bus.unit)
    );

    // transaction sequencer: next values
    always_comb begin
        logic [7:0] cmd_full;
        cmd_full = {cmd_q[6:0], io[0]};
        state_d  = state_q;
        kind_d   = kind_q;
        cnt_d    = cnt_q;
        cmd_d    = cmd_q;
        addr_d   = addr_q;
        mode_d   = mode_q;
        cont_d   = cont_q;
        wrap_d   = wrap_q;
        out_d    = out_q;
        lo_d     = lo_q;
        nib_d    = nib_q;
        oe_d     = oe_q;
        if (cs_hi) begin
            // cs high ends any read, including a wrapping burst
            state_d = ST_IDLE;
            oe_d    = 1'b0;
            nib_d   = 1'b0;
            cnt_d   = 4'h0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    cnt_d = 4'h0;
                    if (cont_q && i_quad_io_enable_bit) begin
                        state_d = ST_ADDR;
                    end else begin
                        state_d = ST_CMD;
                    end
                end
                ST_CMD: begin
                    if (rise) begin
                        cmd_d = cmd_full;
                        cnt_d = cnt_q + 4'h1;
                        if (cnt_q == CMD_CLKS - 4'h1) begin
                            cnt_d   = 4'h0;
                            // unknown codes, a plain all-ones byte
                            // included, are left to other logic
                            state_d = ST_IGNORE;
                            if (i_quad_io_enable_bit) begin
                                case (cmd_full)
                                    CMD_FAST_QUAD: begin
                                        kind_d  = KIND_FAST;
                                        state_d = ST_ADDR;
                                    end
                                    CMD_WORD_QUAD: begin
                                        kind_d  = KIND_WORD;
                                        state_d = ST_ADDR;
                                    end
                                    CMD_OCTAL_QUAD: begin
                                        kind_d  = KIND_OCTAL;
                                        state_d = ST_ADDR;
                                    end
                                    default: state_d = ST_IGNORE;
                                endcase
                            end
                        end
                    end
                end
                ST_ADDR: begin
                    if (rise) begin
                        // address taken as given: alignment is the
                        // host's duty, low bits are not forced
                        addr_d = {addr_q[ADDR_W-5:0], io};
                        cnt_d  = cnt_q + 4'h1;
                        if (cnt_q == ADDR_CLKS - 4'h1) begin
                            cnt_d   = 4'h0;
                            state_d = ST_MODE;
                        end
                    end
                end
                ST_MODE: begin
                    if (rise) begin
                        mode_d = {mode_q[3:0], io};
                        cnt_d  = cnt_q + 4'h1;
                        if (cnt_q == MODE_CLKS - 4'h1) begin
                            cnt_d  = 4'h0;
                            // only bits 5:4 matter; an all-ones reset
                            // byte on line 0 forces bit 4 high and so
                            // leaves continuous mode by itself
                            cont_d = (mode_q[1:0] == CONT_SELECT);
                            if (dummy_of(kind_q) == 4'h0) begin
                                state_d = ST_DATA;
                            end else begin
                                state_d = ST_DUMMY;
                            end
                        end
                    end
                end
                ST_DUMMY: begin
                    if (rise) begin
                        cnt_d = cnt_q + 4'h1;
                        if (cnt_q == dummy_of(kind_q) - 4'h1) begin
                            cnt_d   = 4'h0;
                            state_d = ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    // lines driven only from the first data falling
                    // edge, after the host has let go of them
                    if (fall && !nib_q) begin
                        out_d = i_rd_data[7:4];
                        lo_d  = i_rd_data[3:0];
                        nib_d = 1'b1;
                        oe_d  = 1'b1;
                    end else if (adv) begin
                        out_d  = lo_q;
                        nib_d  = 1'b0;
                        addr_d = wrap_bus.next;
                    end
                end
                ST_IGNORE: state_d = ST_IGNORE;
                default:   state_d = ST_IDLE;
            endcase
        end
        // newest wrap setting overrides, even mid-transaction
        if (i_wrap_load) begin
            wrap_d = i_wrap_setting;
        end
    end

    // transaction sequencer: registers
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state_q <= ST_IDLE;
            kind_q  <= KIND_FAST;
            cnt_q   <= 4'h0;
            cmd_q   <= 8'h00;
            addr_q  <= 24'h000000;
            mode_q  <= 8'h00;
            cont_q  <= 1'b0;
            wrap_q  <= WRAP_RESET;
            out_q   <= 4'h0;
            lo_q    <= 4'h0;
            nib_q   <= 1'b0;
            oe_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            kind_q  <= kind_d;
            cnt_q   <= cnt_d;
            cmd_q   <= cmd_d;
            addr_q  <= addr_d;
            mode_q  <= mode_d;
            cont_q  <= cont_d;
            wrap_q  <= wrap_d;
            out_q   <= out_d;
            lo_q    <= lo_d;
            nib_q   <= nib_d;
            oe_q    <= oe_d;
        end
    end

    // outputs straight from registers, except o_read_active, decoded from state_q
    assign o_quad_line    = out_q;
    assign o_quad_line_oe = {4{oe_q}};
    assign o_rd_addr      = addr_q;
    assign o_cont_mode    = cont_q;
    assign o_read_active  = (state_q == ST_DATA);

    // helper logic for the checks below
    logic [3:0]        dummy_seen_q;
    logic              sel_now;
    logic              cont_go;
    logic [3:0]        rd_hi;
    logic [ADDR_W-1:0] sect_base;

    assign sel_now   = (mode_q[1:0] == CONT_SELECT);
    assign cont_go   = cont_q && i_quad_io_enable_bit;
    assign rd_hi     = i_rd_data[7:4];
    assign sect_base = {addr_q[ADDR_W-1:8], addr_q[7:0] & ~wrap_bus.mask};

    // counts link rising edges spent in the dummy phase
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || state_q == ST_IDLE) begin
            dummy_seen_q <= 4'h0;
        end else if (rise && state_q == ST_DUMMY) begin
            dummy_seen_q <= dummy_seen_q + 4'h1;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    property p_wrap_section;
        (adv && wrap_bus.apply) |=> (sect_base == $past(sect_base));
    endproperty
    a_wrap_section: assert property (p_wrap_section)
        else $error("wrapped read left its section");

    property p_wrap_turn;
        (adv && wrap_bus.apply &&
         ((addr_q[7:0] & wrap_bus.mask) == wrap_bus.mask))
        |=> ((addr_q[7:0] & wrap_bus.mask) == 8'h00);
    endproperty
    a_wrap_turn: assert property (p_wrap_turn)
        else $error("wrap did not return to section base");

    property p_wrap_reset;
        $rose(i_reset_n) |-> (wrap_q == WRAP_RESET);
    endproperty
    a_wrap_reset: assert property (p_wrap_reset)
        else $error("wrap setting not disabled after reset");

    property p_dummy_fast;
        (state_q == ST_DATA && $past(state_q) == ST_DUMMY &&
         kind_q == KIND_FAST) |-> (dummy_seen_q == 4'h4);
    endproperty
    a_dummy_fast: assert property (p_dummy_fast)
        else $error("fast quad read dummy count wrong");

    property p_dummy_word;
        (state_q == ST_DATA && $past(state_q) == ST_DUMMY &&
         kind_q == KIND_WORD) |-> (dummy_seen_q == 4'h2);
    endproperty
    a_dummy_word: assert property (p_dummy_word)
        else $error("word quad read dummy count wrong");

    property p_octal_direct;
        (state_q == ST_DATA && $past(state_q) == ST_MODE)
        |-> (kind_q == KIND_OCTAL);
    endproperty
    a_octal_direct: assert property (p_octal_direct)
        else $error("read skipped dummy clocks");

    property p_qe_gate;
        (state_q == ST_ADDR && $past(state_q) == ST_CMD)
        |-> $past(i_quad_io_enable_bit);
    endproperty
    a_qe_gate: assert property (p_qe_gate)
        else $error("quad read accepted without quad enable");

    property p_cont_set;
        (rise && state_q == ST_MODE && cnt_q == 4'h1 && !cs_hi)
        |=> (cont_q == $past(sel_now));
    endproperty
    a_cont_set: assert property (p_cont_set)
        else $error("continuous mode not taken from select pair");

    property p_cont_skip;
        (state_q == ST_IDLE && !cs_hi)
        |=> ((state_q == ST_ADDR) == $past(cont_go));
    endproperty
    a_cont_skip: assert property (p_cont_skip)
        else $error("instruction skip does not follow mode");

    property p_high_nibble;
        (fall && state_q == ST_DATA && !nib_q && !cs_hi)
        |=> (o_quad_line == $past(rd_hi)) && (o_quad_line_oe == 4'hF);
    endproperty
    a_high_nibble: assert property (p_high_nibble)
        else $error("high nibble not driven first");

    property p_release;
        cs_hi |=> (o_quad_line_oe == 4'h0);
    endproperty
    a_release: assert property (p_release)
        else $error("lines still driven after cs high");

    sequence p_wrap_turn_seen;
        adv && wrap_bus.apply &&
        ((addr_q[7:0] & wrap_bus.mask) == wrap_bus.mask);
    endsequence

    c_wrap_turn:   cover property (p_wrap_turn_seen);
    c_cont_entry:  cover property (state_q == ST_IDLE && !cs_hi && cont_go);
    c_octal_data:  cover property (state_q == ST_DATA &&
                                   kind_q == KIND_OCTAL && adv);
endmodule : qrw_read_seq

/* File: sim/qrw_host_model.sv */
`timescale 1ns/100ps
// quad link host: mode 0 framing, link period of 8 system clocks
module qrw_host_model (
    input  wire logic       i_clk,
    input  wire logic [3:0] i_dev_line,
    input  wire logic [3:0] i_dev_oe,
    output logic            o_cs_n,
    output logic            o_sclk,
    output logic [3:0]      o_line,
    output logic            o_line_oe
);
    logic [7:0] got [0:127];
    logic       oe_seen;

    // link idles with cs high and the clock parked low between frames
    initial begin
        o_cs_n    = 1'b1;
        o_sclk    = 1'b0;
        o_line    = 4'h0;
        o_line_oe = 1'b0;
        oe_seen   = 1'b0;
    end

    // one frame: optional command, address, mode byte, dummies, data
    task automatic frame(input bit with_cmd, input logic [7:0] cmd,
                         input logic [23:0] addr, input logic [7:0] mode,
                         input int dummy, input int nbytes);
        int n_cmd;
        int n_in;
        int j;
        int k;
        n_cmd   = with_cmd ? 8 : 0;
        n_in    = n_cmd + 8;
        oe_seen = 1'b0;
        @(posedge i_clk);
        o_cs_n <= 1'b0;
        for (j = 0; j < n_in + dummy + 2 * nbytes; j++) begin
            @(posedge i_clk);
            o_sclk <= 1'b0;
            k = j - n_cmd;
            if (j < n_cmd) begin
                o_line    <= {3'h0, cmd[7-j]};
                o_line_oe <= 1'b1;
            end else if (j < n_in) begin
                // address then mode byte right behind it, high nibble first
                o_line    <= (k < 6) ? addr[23-4*k -: 4]
                                     : mode[7-4*(k-6) -: 4];
                o_line_oe <= 1'b1;
            end else begin
                // released line: shows a changing pattern, never old data
                o_line    <= ~o_line;
                o_line_oe <= 1'b0;
            end
            repeat (4) @(posedge i_clk);
            o_sclk <= 1'b1;
            repeat (3) @(posedge i_clk);
            // sample late in the high phase, nibble stands until next fall
            @(negedge i_clk);
            oe_seen = oe_seen | (|i_dev_oe);
            k = j - n_in - dummy;
            if (k >= 0) begin
                got[k/2][7-4*(k%2) -: 4] = i_dev_line;
            end
        end
        @(posedge i_clk);
        o_sclk    <= 1'b0;
        o_line_oe <= 1'b0;
        repeat (2) @(posedge i_clk);
        o_cs_n <= 1'b1;
        repeat (16) @(posedge i_clk);
    endtask : frame
endmodule : qrw_host_model

/* File: sim/test_qrw_read_seq.sv */
`timescale 1ns/100ps
module test_qrw_read_seq;
    import qrw_pkg::*;
    logic              i_clk                = 1'b0;
    logic              i_reset_n            = 1'b0;
    logic              i_quad_io_enable_bit = 1'b1;
    logic              i_wrap_load          = 1'b0;
    logic [2:0]        i_wrap_setting       = 3'h4;
    logic [7:0]        rd_data;
    logic              cs_n;
    logic              sclk;
    logic              host_oe;
    logic [3:0]        host_line;
    logic [3:0]        dut_line;
    logic [3:0]        dut_oe;
    logic [3:0]        wire_line;
    logic [ADDR_W-1:0] rd_addr;
    logic              cont_mode;
    logic              read_active;
    logic [31:0]       seed                 = 32'h00013CA3;
    logic [7:0]        cmds [0:2]           = '{CMD_FAST_QUAD, CMD_WORD_QUAD,
                                                CMD_OCTAL_QUAD};
    int                n_mismatch           = 0;
    int                num_checks           = 0;

    always #2 i_clk = ~i_clk;

    // memory contents are a fixed function of the address
    function automatic logic [7:0] mem_byte(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'hA5;
    endfunction : mem_byte

    // address of byte k: wraps inside an aligned section when enabled
    function automatic logic [23:0] exp_addr(input logic [23:0] s,
            input int k, input logic wrap_on, input logic [1:0] len);
        logic [7:0] m;
        m = (WRAP_MIN_BYTES << len) - 8'h01;
        if (!wrap_on) return s + 24'(k);
        return {s[23:8], (s[7:0] & ~m) | ((s[7:0] + 8'(k)) & m)};
    endfunction : exp_addr

    function automatic logic [23:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[23:0];
    endfunction : rnd

    // the line seen by the device: its own drive when dut_oe[0] is set, else the host
    assign wire_line = dut_oe[0] ? dut_line : host_line;
    assign rd_data   = mem_byte(rd_addr);

    qrw_read_seq u_dut (
        .i_clk                (i_clk),
        .i_reset_n            (i_reset_n),
        .i_cs_n               (cs_n),
        .i_sclk               (sclk),
        .i_quad_line          (wire_line),
        .o_quad_line          (dut_line),
        .o_quad_line_oe       (dut_oe),
        .i_quad_io_enable_bit (i_quad_io_enable_bit),
        .i_wrap_load          (i_wrap_load),
        .i_wrap_setting       (i_wrap_setting),
        .o_rd_addr            (rd_addr),
        .i_rd_data            (rd_data),
        .o_cont_mode          (cont_mode),
        .o_read_active        (read_active)
    );

    qrw_host_model u_host (
        .i_clk      (i_clk),
        .i_dev_line (dut_line),
        .i_dev_oe   (dut_oe),
        .o_cs_n     (cs_n),
        .o_sclk     (sclk),
        .o_line     (host_line),
        .o_line_oe  (host_oe)
    );

    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic set_wrap(input logic [2:0] w);
        @(posedge i_clk);
        i_wrap_load    <= 1'b1;
        i_wrap_setting <= w;
        @(posedge i_clk);
        i_wrap_load    <= 1'b0;
    endtask : set_wrap

    // one read frame, then compare every byte and the armed flag
    task automatic do_read(input bit with_cmd, input logic [7:0] cmd,
            input logic [23:0] a, input logic [7:0] mode, input int nb,
            input logic wrap_on, input logic [1:0] len);
        int   dm;
        int   k;
        logic bad;
        dm = (cmd == CMD_FAST_QUAD) ? int'(DUMMY_FAST) :
             (cmd == CMD_WORD_QUAD) ? int'(DUMMY_WORD) : int'(DUMMY_OCTAL);
        u_host.frame(with_cmd, cmd, a, mode, dm, nb);
        bad = 1'b0;
        for (k = 0; k < nb; k++) begin
            if (u_host.got[k] !== mem_byte(exp_addr(a, k, wrap_on, len)))
                bad = 1'b1;
        end
        chk(!bad, "read data");
        chk(cont_mode === (mode[5:4] == CONT_SELECT), "continuous flag");
    endtask : do_read

    // watchdog sized well above the longest expected run
    initial begin
        repeat (90000) @(posedge i_clk);
        n_mismatch++;
        finish_test();
    end

    initial begin
        logic [23:0] a;
        logic [7:0]  m;
        logic [2:0]  w;
        int          s;
        repeat (20) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(negedge i_clk);
        chk(dut_oe === 4'h0 && rd_addr === 24'h0 && cont_mode === 1'b0,
            "reset outputs");
        chk(read_active === 1'b0 && dut_line === 4'h0, "reset idle");
        // default setting is no wrap: crossing an 8-byte edge goes on
        a = rnd();
        a[2:0] = 3'h6;
        do_read(1, CMD_FAST_QUAD, a, 8'h00, 6, 1'b0, 2'h0);
        // every length, then disabled with a nonzero length field
        for (s = 0; s < 5; s++) begin
            w = (s == 4) ? 3'h7 : 3'(s);
            set_wrap(w);
            a = rnd();
            do_read(1, CMD_FAST_QUAD, a, 8'h00, (8 << w[1:0]) + 3,
                    !w[WRAP_DIS_BIT], w[1:0]);
        end
        set_wrap(3'h1);
        a = rnd();
        a[0] = 1'b0;
        do_read(1, CMD_WORD_QUAD, a, 8'h00, 19, 1'b1, 2'h1);
        a[3:0] = 4'h0;
        do_read(1, CMD_OCTAL_QUAD, a, 8'h00, 20, 1'b0, 2'h0);
        set_wrap(3'h4);
        // arm with random spare bits, reuse, then disarm, per kind
        for (s = 0; s < 3; s++) begin
            m = rnd();
            m[5:4] = CONT_SELECT;
            a = rnd();
            a[3:0] = 4'h0;
            do_read(1, cmds[s], a, m, 4, 1'b0, 2'h0);
            a = rnd();
            a[3:0] = 4'h0;
            do_read(0, cmds[s], a, 8'h20, 4, 1'b0, 2'h0);
            m = rnd();
            m[5:4] = 2'h1;
            do_read(0, cmds[s], a, m, 4, 1'b0, 2'h0);
            do_read(1, cmds[s], a, 8'h00, 3, 1'b0, 2'h0);
        end
        // armed, then eight clocks of ones drop continuous mode
        do_read(1, CMD_FAST_QUAD, a, 8'h2C, 2, 1'b0, 2'h0);
        u_host.frame(0, CMD_FAST_QUAD, 24'hFFFFFF, 8'hFF, 0, 0);
        chk(cont_mode === 1'b0, "mode reset");
        do_read(1, CMD_OCTAL_QUAD, a, 8'h00, 3, 1'b0, 2'h0);
        // quad enable low: no command may turn the lines round
        i_quad_io_enable_bit <= 1'b0;
        for (s = 0; s < 3; s++) begin
            u_host.frame(1, cmds[s], a, 8'h00, 4, 2);
            chk(u_host.oe_seen === 1'b0, "refused read");
        end
        finish_test();
    end
endmodule : test_qrw_read_seq
